// *** design/ptw_pot_slave.sv ***
// two-wire command slave, command buffer and wiper tap decoder
//
// Notes on behaviour
// - the ten wiper bits select exactly one of 1024 tap switches.
// - tap selection is one-hot at all times.
// - SDA changes only while SCL is low, except start and stop.
// - bus traffic is ignored until a start condition is seen.
// - start is SDA falling while SCL high; the slave detects it.
// - stop is SDA rising while SCL high; the slave detects it.
// - after eight bits the sender releases SDA; receiver acks on ninth clock.
// - ack the matching address byte, the instruction byte and data bytes.
// - stop after a nonvolatile write starts it; inputs ignored until done.
// - no address ack during an internal write; master may poll.
// - identification byte carries the device type nibble then a zero bit.
// - both slave-select bits must equal the two strap inputs.
// - identification bit zero gives direction, one read, zero write.
// - instruction byte: opcode, zero, two select bits, two zeros.
// - select bits 00..11 choose stored setting zero to three.
// - read, opcode 100, select zero returns the wiper position.
// - write, opcode 101, select zero loads the wiper position.
// - read, opcode 101 returns the selected stored setting.
// - write, opcode 110 writes the selected stored setting, nonvolatile.
// - read, opcode 110 copies the selected stored setting to the wiper.
// - write, opcode 111 copies the wiper into the selected setting.
// - sample SDA on rising SCL, shift out after falling SCL.
// - write protect low blocks every nonvolatile write.
// - after power-up stored setting zero is loaded into the wiper.
// - a nonvolatile write finishes within 10 ms.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ptw_cmd_fifo #(
   parameter int WIDTH = ptw_pkg::CMD_WIDTH,
   parameter int DEPTH = ptw_pkg::FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } ptw_fifo_state_type;

   ptw_fifo_state_type st_reg;
   ptw_fifo_state_type st_next;
   logic               push;
   logic               pop;

   assign in_ready = st_reg.count != (AW + 1)'(DEPTH);
   assign out_valid = st_reg.count != '0;
   assign out_data = st_reg.mem[st_reg.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
      st_next.count = st_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // ptw_cmd_fifo

////////////////////////////////////////////////////////////////////////////////
module ptw_pot_slave #(
   parameter logic [3:0]  DEVICE_TYPE = 4'hA, // arbitrary value
   parameter int unsigned NV_WRITE_CYCLES = ptw_pkg::NV_WRITE_CYCLES
) (
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   output logic               sda_out,
   output logic               sda_oe,
   input  wire logic          addr_strap_hi,
   input  wire logic          addr_strap_lo,
   input  wire logic          write_protect_b,
   output logic [9:0]         wiper_position_bits,
   output logic [1023:0]      tap_select,
   output logic               nv_busy
);
   typedef struct packed {
      logic                                scl_s1;
      logic                                scl_s2;
      logic                                scl_d;
      logic                                sda_s1;
      logic                                sda_s2;
      logic                                sda_d;
      logic                                wp_s1;
      logic                                wp_s2;
      logic [1:0]                          strap_s1;
      logic [1:0]                          strap_s2;
      ptw_pkg::ptw_state_type              state;
      logic [3:0]                          bit_cnt;
      logic [2:0]                          byte_cnt;
      logic [7:0]                          shift;
      logic                                is_read;
      logic                                sends;
      ptw_pkg::ptw_cmd_type                kind;
      logic [1:0]                          sel;
      logic [1:0]                          data_hi;
      logic [9:0]                          rd_val;
      logic [9:0]                          cmd_val;
      logic                                mack_ok;
      logic                                pending;
      logic                                sda_out;
      logic                                sda_oe;
      logic [3:0][9:0]                     stored;
      logic [9:0]                          wiper;
      logic                                recall_done;
      logic                                busy;
      logic [ptw_pkg::NV_CNT_WIDTH-1:0]    nv_cnt;
      logic [1023:0]                       tap;
   } ptw_top_state_type;

   ptw_top_state_type                st;
   ptw_top_state_type                st_next;
   logic                             scl_rise;
   logic                             scl_fall;
   logic                             start_evt;
   logic                             stop_evt;
   logic                             fifo_push;
   logic                             fifo_in_ready;
   logic                             fifo_out_valid;
   logic                             fifo_out_ready;
   logic [ptw_pkg::CMD_WIDTH-1:0]    fifo_in_data;
   logic [ptw_pkg::CMD_WIDTH-1:0]    fifo_out_data;
   ptw_pkg::ptw_cmd_type             pop_kind;
   logic [1:0]                       pop_sel;
   logic [9:0]                       pop_val;

   assign sda_out = st.sda_out;
   assign sda_oe = st.sda_oe;
   assign wiper_position_bits = st.wiper;
   assign tap_select = st.tap;
   assign nv_busy = st.busy;

   // bus events, seen only on the second synchroniser stage and its delay
   assign scl_rise = st.scl_s2 && !st.scl_d;
   assign scl_fall = !st.scl_s2 && st.scl_d;
   assign start_evt = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
   assign stop_evt = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;

   assign fifo_in_data = {st.kind, st.sel, st.cmd_val};
   assign fifo_out_ready = !st.busy && st.recall_done;
   assign pop_kind = ptw_pkg::ptw_cmd_type'(fifo_out_data[ptw_pkg::CMD_KIND_LSB +: 2]);
   assign pop_sel = fifo_out_data[ptw_pkg::CMD_SEL_LSB +: 2];
   assign pop_val = fifo_out_data[ptw_pkg::VAL_WIDTH-1:0];

   ptw_cmd_fifo #(
      .WIDTH (ptw_pkg::CMD_WIDTH),
      .DEPTH (ptw_pkg::FIFO_DEPTH)
   ) u_cmd_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic       accept;
      logic       legal;
      logic [2:0] op;
      logic [7:0] load;
      accept = 1'b0;
      legal = 1'b0;
      op = st.shift[7:5];
      load = '0;
      st_next = st;
      fifo_push = 1'b0;

      st_next.scl_s1 = scl_in;
      st_next.scl_s2 = st.scl_s1;
      st_next.scl_d = st.scl_s2;
      st_next.sda_s1 = sda_in;
      st_next.sda_s2 = st.sda_s1;
      st_next.sda_d = st.sda_s2;
      st_next.wp_s1 = write_protect_b;
      st_next.wp_s2 = st.wp_s1;
      st_next.strap_s1 = {addr_strap_hi, addr_strap_lo};
      st_next.strap_s2 = st.strap_s1;

      // instruction legality against direction
      if (st.is_read) begin
         legal = (op == ptw_pkg::OPC_WIPER_RD && st.shift[3:2] == 2'b00)
            || op == ptw_pkg::OPC_WIPER_WR || op == ptw_pkg::OPC_STORED;
      end else begin
         legal = (op == ptw_pkg::OPC_WIPER_WR && st.shift[3:2] == 2'b00)
            || op == ptw_pkg::OPC_STORED || op == ptw_pkg::OPC_SAVE;
      end
      legal = legal && !st.shift[4] && st.shift[1:0] == 2'b00;

      unique case (st.byte_cnt)
         3'h0: accept = st.shift[7:4] == DEVICE_TYPE && !st.shift[3]
            && st.shift[2:1] == st.strap_s2
            && !st.busy && fifo_in_ready;
         3'h1: accept = legal;
         3'h2, 3'h3: accept = !st.is_read && (st.kind == ptw_pkg::CMD_WR_WIPER
            || st.kind == ptw_pkg::CMD_WR_STORED);
         default: accept = 1'b0;
      endcase

      if (start_evt) begin
         st_next.state = ptw_pkg::ST_RECV;
         st_next.bit_cnt = '0;
         st_next.byte_cnt = '0;
         st_next.sda_oe = 1'b0;
         st_next.pending = 1'b0;
      end else if (stop_evt) begin
         fifo_push = st.pending;
         st_next.pending = 1'b0;
         st_next.state = ptw_pkg::ST_IDLE;
         st_next.sda_oe = 1'b0;
      end else begin
         unique case (st.state)
            ptw_pkg::ST_IDLE: begin
            end
            ptw_pkg::ST_RECV: begin
               if (scl_rise) begin
                  st_next.shift = {st.shift[6:0], st.sda_s2};
                  st_next.bit_cnt = st.bit_cnt + 4'h1;
               end else if (scl_fall && st.bit_cnt == ptw_pkg::BITS_PER_BYTE) begin
                  st_next.bit_cnt = '0;
                  if (accept) begin
                     st_next.sda_oe = 1'b1;
                     st_next.state = ptw_pkg::ST_ACK;
                  end else begin
                     st_next.state = ptw_pkg::ST_IDLE;
                  end
                  unique case (st.byte_cnt)
                     3'h0: st_next.is_read = st.shift[0];
                     3'h1: begin
                        st_next.sel = st.shift[3:2];
                        st_next.sends = st.is_read && op != ptw_pkg::OPC_STORED;
                        st_next.rd_val = (op == ptw_pkg::OPC_WIPER_RD) ? st.wiper
                           : st.stored[st.shift[3:2]];
                        if (op == ptw_pkg::OPC_WIPER_WR) begin
                           st_next.kind = ptw_pkg::CMD_WR_WIPER;
                        end else if (op == ptw_pkg::OPC_STORED) begin
                           st_next.kind = st.is_read ? ptw_pkg::CMD_LOAD_WIPER
                              : ptw_pkg::CMD_WR_STORED;
                        end else begin
                           st_next.kind = ptw_pkg::CMD_SAVE_WIPER;
                        end
                        st_next.pending = accept && ((st.is_read && op == ptw_pkg::OPC_STORED)
                           || (!st.is_read && op == ptw_pkg::OPC_SAVE));
                     end
                     3'h2: st_next.data_hi = st.shift[1:0];
                     3'h3: begin
                        st_next.cmd_val = {st.data_hi, st.shift};
                        st_next.pending = accept;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            ptw_pkg::ST_ACK: begin
               if (scl_fall) begin
                  st_next.sda_oe = 1'b0;
                  st_next.byte_cnt = (st.byte_cnt == 3'h4) ? st.byte_cnt : st.byte_cnt + 3'h1;
                  if (st.sends && st.byte_cnt == 3'h1) begin
                     load = {6'h00, st.rd_val[9:8]};
                     st_next.sda_oe = !load[7];
                     st_next.shift = {load[6:0], 1'b0};
                     st_next.state = ptw_pkg::ST_SEND;
                  end else begin
                     st_next.state = ptw_pkg::ST_RECV;
                  end
               end
            end
            ptw_pkg::ST_SEND: begin
               if (scl_rise) begin
                  st_next.bit_cnt = st.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (st.bit_cnt == ptw_pkg::BITS_PER_BYTE) begin
                     st_next.sda_oe = 1'b0;
                     st_next.bit_cnt = '0;
                     st_next.state = ptw_pkg::ST_MACK;
                  end else begin
                     st_next.sda_oe = !st.shift[7];
                     st_next.shift = {st.shift[6:0], 1'b0};
                  end
               end
            end
            ptw_pkg::ST_MACK: begin
               if (scl_rise) begin
                  st_next.mack_ok = !st.sda_s2;
               end else if (scl_fall) begin
                  if (st.mack_ok && st.byte_cnt == 3'h2) begin
                     load = st.rd_val[7:0];
                     st_next.sda_oe = !load[7];
                     st_next.shift = {load[6:0], 1'b0};
                     st_next.byte_cnt = ptw_pkg::LAST_DATA_BYTE;
                     st_next.state = ptw_pkg::ST_SEND;
                  end else begin
                     st_next.state = ptw_pkg::ST_IDLE;
                  end
               end
            end
            default: st_next.state = ptw_pkg::ST_IDLE;
         endcase
      end

      // command execution and nonvolatile write timing
      if (st.busy) begin
         if (st.nv_cnt == '0) begin
            st_next.busy = 1'b0;
         end else begin
            st_next.nv_cnt = st.nv_cnt - 1'b1;
         end
      end
      if (!st.recall_done) begin
         st_next.wiper = st.stored[0];
         st_next.recall_done = 1'b1;
      end else if (fifo_out_valid && fifo_out_ready) begin
         unique case (pop_kind)
            ptw_pkg::CMD_WR_WIPER: st_next.wiper = pop_val;
            ptw_pkg::CMD_LOAD_WIPER: st_next.wiper = st.stored[pop_sel];
            ptw_pkg::CMD_WR_STORED, ptw_pkg::CMD_SAVE_WIPER: begin
               if (st.wp_s2) begin
                  st_next.stored[pop_sel] = (pop_kind == ptw_pkg::CMD_WR_STORED)
                     ? pop_val : st.wiper;
                  st_next.busy = 1'b1;
                  st_next.nv_cnt = ptw_pkg::NV_CNT_WIDTH'(NV_WRITE_CYCLES - 1);
               end
            end
         endcase
      end

      st_next.tap = '0;
      st_next.tap[st_next.wiper] = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.stored <= {ptw_pkg::SETTING_COUNT{ptw_pkg::STORED_RESET}};
         // idle bus level, so no false edge after reset
         st.scl_s1 <= 1'b1;
         st.scl_s2 <= 1'b1;
         st.scl_d <= 1'b1;
         st.sda_s1 <= 1'b1;
         st.sda_s2 <= 1'b1;
         st.sda_d <= 1'b1;
         // wiper resets to zero, so tap zero is on
         st.tap[0] <= 1'b1;
      end else begin
         st <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking ptw_cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence start_seen;
      start_evt;
   endsequence
   sequence ack_entry;
      (st.state != ptw_pkg::ST_ACK) ##1 (st.state == ptw_pkg::ST_ACK);
   endsequence
   sequence wiper_pop;
      fifo_out_valid && fifo_out_ready && st.recall_done && pop_kind == ptw_pkg::CMD_WR_WIPER;
   endsequence

   tap_onehot_a: assert property ($onehot(st.tap))
      else $error("tap selection not one-hot");
   tap_decode_a: assert property (st.tap == (1024'(1) << st.wiper))
      else $error("tap does not match wiper");
   start_recv_a: assert property (start_seen |=> st.state == ptw_pkg::ST_RECV
      && st.byte_cnt == 3'h0 && !st.sda_oe)
      else $error("start not taken");
   stop_idle_a: assert property (stop_evt |=> st.state == ptw_pkg::ST_IDLE && !st.sda_oe)
      else $error("stop not taken");
   sda_scl_low_a: assert property ($changed(st.sda_oe) && !$past(start_evt)
      && !$past(stop_evt) |-> !$past(st.scl_s2))
      else $error("sda moved while scl high");
   ack_drive_a: assert property (ack_entry |-> st.sda_oe ##1 (st.sda_oe
      || st.state != ptw_pkg::ST_ACK))
      else $error("ack not driven");
   addr_busy_a: assert property (ack_entry ##0 st.byte_cnt == 3'h0 |-> !$past(st.busy))
      else $error("address acked while busy");
   id_match_a: assert property (ack_entry ##0 st.byte_cnt == 3'h0 |->
      $past(st.shift[7:4]) == DEVICE_TYPE && !$past(st.shift[3])
      && $past(st.shift[2:1]) == $past(st.strap_s2))
      else $error("mismatched address acked");
   wp_block_a: assert property (!st.wp_s2 |=> $stable(st.stored))
      else $error("stored setting written under protect");
   nv_length_a: assert property ($rose(st.busy) |->
      st.nv_cnt == ptw_pkg::NV_CNT_WIDTH'(NV_WRITE_CYCLES - 1))
      else $error("nonvolatile write length wrong");
   nv_bound_a: assert property (st.busy |-> st.nv_cnt < ptw_pkg::NV_CNT_WIDTH'(
      ptw_pkg::NV_WRITE_MAX_CYCLES))
      else $error("nonvolatile write too long");
   recall_a: assert property ($rose(st.recall_done) |-> st.wiper == $past(st.stored[0]))
      else $error("power-up recall missing");
   wiper_write_a: assert property (wiper_pop |=> st.wiper == $past(pop_val))
      else $error("wiper write lost");
endmodule // ptw_pot_slave

`default_nettype wire

// *** design/ptw_pkg.sv ***
// constants and types of the two-wire potentiometer command slave
package ptw_pkg;

   // potentiometer geometry
   localparam int VAL_WIDTH = 10;
   localparam int TAP_COUNT = 1024;
   localparam int SETTING_COUNT = 4;
   localparam logic [9:0] STORED_RESET = 10'h000;

   // clock and nonvolatile write timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int NV_WRITE_TIME_US = 5000;
   localparam int NV_WRITE_MAX_US = 10000;
   localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int NV_WRITE_MAX_CYCLES = NV_WRITE_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int NV_CNT_WIDTH = 18;

   // byte framing on the bus
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] LAST_DATA_BYTE = 3'h3;

   // instruction opcodes, upper three bits of the instruction byte
   localparam logic [2:0] OPC_WIPER_RD = 3'h4;
   localparam logic [2:0] OPC_WIPER_WR = 3'h5;
   localparam logic [2:0] OPC_STORED = 3'h6;
   localparam logic [2:0] OPC_SAVE = 3'h7;

   // command word carried through the buffer
   localparam int CMD_WIDTH = 14;
   localparam int CMD_KIND_LSB = 12;
   localparam int CMD_SEL_LSB = 10;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      CMD_WR_WIPER   = 2'b00,
      CMD_WR_STORED  = 2'b01,
      CMD_LOAD_WIPER = 2'b10,
      CMD_SAVE_WIPER = 2'b11
   } ptw_cmd_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_ACK  = 3'b010,
      ST_SEND = 3'b011,
      ST_MACK = 3'b100
   } ptw_state_type;

endpackage

// *** test/ptw_bus_master.sv ***
// two-wire bus master model: drives the bus clock and open-drain data
`timescale 1ns/1ns
`default_nettype none
module ptw_bus_master (
   output logic     scl,
   output logic     sda_drv,
   input wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // data set early in the low phase, sampled at the rise
   task automatic bit_slot(input logic b, output logic r);
      sda_drv = b;
      #160 scl = 1'b1;
      r = sda_wire;
      #120 scl = 1'b0;
      #40;
   endtask
   task automatic byte_slot(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                            output logic ack);
      for (int i = 7; i >= 0; i--) bit_slot(b[i], r[i]);
      bit_slot(ack_in, ack);
      ack = ~ack;
   endtask
   task automatic command(input logic [7:0] id, input logic [7:0] ins, input logic four,
                          input logic [9:0] wval, output logic [3:0] acks,
                          output logic [9:0] rval);
      logic [7:0] hi;
      logic [7:0] lo;
      acks = 4'h0;
      rval = 10'h000;
      sda_drv = 1'b1;
      #40 scl = 1'b1;
      #80 sda_drv = 1'b0;
      #80 scl = 1'b0;
      #40 byte_slot(id, 1'b1, hi, acks[3]);
      if (acks[3]) begin
         byte_slot(ins, 1'b1, hi, acks[2]);
         if (four && id[0]) begin
            byte_slot(8'hFF, 1'b0, hi, acks[1]);
            byte_slot(8'hFF, 1'b1, lo, acks[0]);
            rval = {hi[1:0], lo};
         end else if (four) begin
            byte_slot({6'h00, wval[9:8]}, 1'b1, hi, acks[1]);
            byte_slot(wval[7:0], 1'b1, lo, acks[0]);
         end
      end
      sda_drv = 1'b0;
      #160 scl = 1'b1;
      #80 sda_drv = 1'b1;
      #80;
   endtask
endmodule // ptw_bus_master
`default_nettype wire

// *** test/tb_ptw_pot_slave.sv ***
// self-checking bench of the two-wire potentiometer command slave
`timescale 1ns/1ns
`default_nettype none
module tb_ptw_pot_slave;
   typedef struct {
      logic [7:0] id;
      logic [7:0] ins;
      logic       four;
      logic [9:0] wval;
      logic [3:0] acks;
      logic [9:0] rval;
      logic [9:0] wip;
   } ptw_row_type;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          wp_b = 1'b1;
   logic          scl;
   logic          sda_drv;
   logic          sda_oe;
   logic          sda_out;
   logic [9:0]    wiper;
   logic [1023:0] taps;
   logic          nv_busy;
   logic [3:0]    acks;
   logic [9:0]    rval;
   int            num_errors = 0;
   int            compares = 0;
   // open drain: pulled low by the master driving zero, or by the slave while enabled and driving zero
   wire logic     sda_wire = sda_drv & ~(sda_oe & ~sda_out);
   ptw_row_type   rows [15] = '{
      '{8'hA4, 8'hA0, 1'b1, 10'h155, 4'hF, 10'h000, 10'h155},
      '{8'hA5, 8'h80, 1'b1, 10'h000, 4'hE, 10'h155, 10'h155},
      '{8'hA4, 8'hC8, 1'b1, 10'h2AA, 4'hF, 10'h000, 10'h155},
      '{8'hA5, 8'hA8, 1'b1, 10'h000, 4'hE, 10'h2AA, 10'h155},
      '{8'hA5, 8'hC8, 1'b0, 10'h000, 4'hC, 10'h000, 10'h2AA},
      '{8'hA4, 8'hA0, 1'b1, 10'h3FF, 4'hF, 10'h000, 10'h3FF},
      '{8'hA4, 8'hE4, 1'b0, 10'h000, 4'hC, 10'h000, 10'h3FF},
      '{8'hA5, 8'hA4, 1'b1, 10'h000, 4'hE, 10'h3FF, 10'h3FF},
      '{8'hA5, 8'hC0, 1'b0, 10'h000, 4'hC, 10'h000, 10'h000},
      '{8'hA0, 8'hA0, 1'b1, 10'h1F0, 4'h0, 10'h000, 10'h000},
      '{8'h34, 8'hA0, 1'b1, 10'h1F0, 4'h0, 10'h000, 10'h000},
      '{8'hAC, 8'hA0, 1'b1, 10'h1F0, 4'h0, 10'h000, 10'h000},
      '{8'hA4, 8'hB0, 1'b1, 10'h1F0, 4'h8, 10'h000, 10'h000},
      '{8'hA4, 8'hA1, 1'b1, 10'h1F0, 4'h8, 10'h000, 10'h000},
      '{8'hA4, 8'h80, 1'b1, 10'h1F0, 4'h8, 10'h000, 10'h000}
   };

   always #20 clk = ~clk;

   ptw_pot_slave #(.DEVICE_TYPE(4'hA), .NV_WRITE_CYCLES(200)) u_dut (
      .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_strap_hi(1'b1), .addr_strap_lo(1'b0),
      .write_protect_b(wp_b), .wiper_position_bits(wiper), .tap_select(taps),
      .nv_busy(nv_busy));

   ptw_bus_master u_mst (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_val(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // let the command land, then wait out any nonvolatile write
   task automatic settle(input int n);
      int k;
      k = 0;
      repeat (8) @(posedge clk);
      while (nv_busy !== 1'b0 && k < n) begin
         @(posedge clk);
         k++;
      end
      if (nv_busy !== 1'b0) begin
         num_errors++;
         test_done();
      end
      #1;
   endtask
   task automatic run(input logic [7:0] id, input logic [7:0] ins, input logic four,
                      input logic [9:0] wval);
      u_mst.command(id, ins, four, wval, acks, rval);
   endtask

////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      settle(4);
      cmp_val(wiper, 10'h000);
      foreach (rows[i]) begin
         run(rows[i].id, rows[i].ins, rows[i].four, rows[i].wval);
         settle(300);
         cmp_flag(acks, rows[i].acks);
         cmp_val(rval, rows[i].rval);
         cmp_val(wiper, rows[i].wip);
         cmp_flag({3'h0, taps === (1024'h1 << rows[i].wip)}, 4'h1);
      end
      run(8'hA4, 8'hCC, 1'b1, 10'h0F0);
      run(8'hA5, 8'hA4, 1'b1, 10'h000);
      cmp_flag(acks, 4'h0);
      cmp_flag({3'h0, nv_busy}, 4'h1);
      settle(300);
      run(8'hA5, 8'hAC, 1'b1, 10'h000);
      cmp_val(rval, 10'h0F0);
      wp_b = 1'b0;
      run(8'hA4, 8'hCC, 1'b1, 10'h111);
      settle(2);
      run(8'hA4, 8'hEC, 1'b0, 10'h000);
      settle(2);
      run(8'hA5, 8'hAC, 1'b1, 10'h000);
      cmp_val(rval, 10'h0F0);
      run(8'hA4, 8'hA0, 1'b1, 10'h2C3);
      settle(2);
      cmp_val(wiper, 10'h2C3);
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      settle(4);
      cmp_val(wiper, 10'h000);
      cmp_flag({3'h0, taps === 1024'h1}, 4'h1);
      test_done();
   end
endmodule // tb_ptw_pot_slave
`default_nettype wire
